//--- design/scs_status_word.sv
// Functional notes
// [RULE_01] Bit 0: offline reads 0, passive idle 1
// [RULE_02] Bit 1: indication held in buffer
// [RULE_03] Bit 2: diagnostics not yet fetched by master
// [RULE_04] Bit 3: access beyond 1.5 kB memory
// [RULE_05] Addresses of 1536 and above fold down by 1024
// [RULE_06] Bits 5:4 protocol state, 11 never shown
// [RULE_07] Bits 7:6 watchdog state, 11 unused
// [RULE_08] Bits 11:8 detected baud rate code
// [RULE_09] Status word mirrors state, read only
// [RULE_10] Bits 15:12 fixed release number
// [RULE_11] All fields registered together each clock
`timescale 1ns/100ps

module scs_status_word (
   input  wire logic                            aclk,                       // Clock, 200 MHz
   input  wire logic                            aresetn,                    // Sync reset, low
   // AXI4-Lite write address
   input  wire logic [scs_pkg::ADDR_W-1:0]      s_axi_awaddr,               // Write address
   input  wire logic                            s_axi_awvalid,              // Address valid
   output logic                                 s_axi_awready,              // Address ready
   // AXI4-Lite write data
   input  wire logic [scs_pkg::DATA_W-1:0]      s_axi_wdata,                // Write data
   input  wire logic [scs_pkg::STRB_W-1:0]      s_axi_wstrb,                // Byte enables
   input  wire logic                            s_axi_wvalid,               // Data valid
   output logic                                 s_axi_wready,               // Data ready
   // AXI4-Lite write response
   output logic      [1:0]                      s_axi_bresp,                // Write response
   output logic                                 s_axi_bvalid,               // Response valid
   input  wire logic                            s_axi_bready,               // Response ready
   // AXI4-Lite read address
   input  wire logic [scs_pkg::ADDR_W-1:0]      s_axi_araddr,               // Read address
   input  wire logic                            s_axi_arvalid,              // Address valid
   output logic                                 s_axi_arready,              // Address ready
   // AXI4-Lite read data
   output logic      [scs_pkg::DATA_W-1:0]      s_axi_rdata,                // Read data
   output logic      [1:0]                      s_axi_rresp,                // Read response
   output logic                                 s_axi_rvalid,               // Data valid
   input  wire logic                            s_axi_rready,               // Data ready
   // Controller state
   input  wire logic                            ctrl_passive_idle,          // 1 passive idle
   input  wire logic                            indication_buffered_flag,   // Indication held
   input  wire logic                            diag_pending,               // Diag not fetched
   input  wire logic [1:0]                      slave_protocol_state_field, // Protocol state
   input  wire logic [1:0]                      watchdog_state_field,       // Watchdog state
   input  wire logic [3:0]                      baud_code,                  // Detected baud
   // Internal memory access
   input  wire logic                            mem_access_valid,           // Access strobe
   input  wire logic [scs_pkg::MEM_ADDR_W-1:0]  mem_access_addr,            // Requested address
   output logic                                 mem_folded_valid,           // Folded strobe
   output logic      [scs_pkg::MEM_ADDR_W-1:0]  mem_folded_addr,            // Folded address
   // Interrupt
   output logic                                 irq                         // Level, high
);

   // **********
   // Declarations
   // **********
   logic [1:0]                     dp_reg;
   logic [1:0]                     dp_next;
   logic [1:0]                     wd_reg;
   logic [1:0]                     wd_next;
   logic [3:0]                     baud_reg;
   logic [3:0]                     baud_next;
   logic                           passive_reg;
   logic                           passive_next;
   logic                           ind_reg;
   logic                           ind_next;
   logic                           diag_reg;
   logic                           diag_next;
   logic [scs_pkg::SW_W-1:0]       status_word_reg;
   logic [scs_pkg::SW_W-1:0]       status_word_next;

   logic [scs_pkg::EV_W-1:0]       event_reg;
   logic [scs_pkg::EV_W-1:0]       event_next;
   logic [scs_pkg::EV_W-1:0]       mask_reg;
   logic [scs_pkg::EV_W-1:0]       mask_next;
   logic [scs_pkg::EV_W-1:0]       event_set;
   logic [scs_pkg::EV_W-1:0]       event_clr;
   logic                           irq_reg;
   logic                           irq_next;

   logic                           aw_held_reg;
   logic                           aw_held_next;
   logic [scs_pkg::ADDR_W-1:0]     awaddr_reg;
   logic [scs_pkg::ADDR_W-1:0]     awaddr_next;
   logic                           w_held_reg;
   logic                           w_held_next;
   logic [scs_pkg::DATA_W-1:0]     wdata_reg;
   logic [scs_pkg::DATA_W-1:0]     wdata_next;
   logic [scs_pkg::STRB_W-1:0]     wstrb_reg;
   logic [scs_pkg::STRB_W-1:0]     wstrb_next;
   logic                           awready_reg;
   logic                           awready_next;
   logic                           wready_reg;
   logic                           wready_next;
   logic                           bvalid_reg;
   logic                           bvalid_next;
   logic [1:0]                     bresp_reg;
   logic [1:0]                     bresp_next;
   logic                           arready_reg;
   logic                           arready_next;
   logic                           rvalid_reg;
   logic                           rvalid_next;
   logic [1:0]                     rresp_reg;
   logic [1:0]                     rresp_next;
   logic [scs_pkg::DATA_W-1:0]     rdata_reg;
   logic [scs_pkg::DATA_W-1:0]     rdata_next;

   logic                           wr_fire;
   logic                           wr_event;
   logic                           wr_mask;
   logic                           mem_violation;

   // **********
   // Memory address folding
   // **********
   scs_addr_fold u_fold (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .access_valid     (mem_access_valid),
      .access_addr      (mem_access_addr),
      .folded_valid_reg (mem_folded_valid),
      .folded_addr_reg  (mem_folded_addr),
      .violation_reg    (mem_violation)
   );

   // **********
   // Controller state capture
   // **********
   always_comb begin
      passive_next = ctrl_passive_idle;                                     // [RULE_01]
      ind_next     = indication_buffered_flag;                              // [RULE_02]
      diag_next    = diag_pending;                                          // [RULE_03]
      baud_next    = baud_code;                                             // [RULE_08]
      // An illegal code keeps the last legal one, so 11 never reaches software
      dp_next      = (slave_protocol_state_field == scs_pkg::DP_ILLEGAL)
                     ? dp_reg : slave_protocol_state_field;                 // [RULE_06]
      wd_next      = (watchdog_state_field == scs_pkg::WD_ILLEGAL)
                     ? wd_reg : watchdog_state_field;                       // [RULE_07]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         passive_reg <= 1'b0;
         ind_reg     <= 1'b0;
         diag_reg    <= 1'b0;
         baud_reg    <= scs_pkg::BAUD_RESET;
         dp_reg      <= scs_pkg::DP_WAIT_PARAM;
         wd_reg      <= scs_pkg::WD_BAUD_SEARCH;
      end else begin
         passive_reg <= passive_next;
         ind_reg     <= ind_next;
         diag_reg    <= diag_next;
         baud_reg    <= baud_next;
         dp_reg      <= dp_next;
         wd_reg      <= wd_next;
      end
   end

   // **********
   // Status word snapshot
   // **********
   // One snapshot per clock keeps every field of a read coherent
   always_comb begin
      status_word_next = '0;
      status_word_next[scs_pkg::SW_PASSIVE_BIT]          = passive_reg;      // [RULE_01]
      status_word_next[scs_pkg::SW_IND_BIT]              = ind_reg;          // [RULE_02]
      status_word_next[scs_pkg::SW_DIAG_BIT]             = diag_reg;         // [RULE_03]
      status_word_next[scs_pkg::SW_VIOL_BIT]             =
         event_reg[scs_pkg::EV_VIOL_BIT];                                    // [RULE_04]
      status_word_next[scs_pkg::SW_DP_LSB +: 2]          = dp_reg;           // [RULE_06]
      status_word_next[scs_pkg::SW_WD_LSB +: 2]          = wd_reg;           // [RULE_07]
      status_word_next[scs_pkg::SW_BAUD_LSB +: 4]        = baud_reg;         // [RULE_08]
      status_word_next[scs_pkg::SW_REL_LSB +: 4]         =
         scs_pkg::RELEASE_NUMBER;                                            // [RULE_10]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_word_reg <= scs_pkg::SW_RESET;
      end else begin
         status_word_reg <= status_word_next;                                // [RULE_11]
      end
   end

   // **********
   // Events, mask and interrupt
   // **********
   always_comb begin
      event_set                      = '0;
      event_set[scs_pkg::EV_VIOL_BIT] = mem_violation;                       // [RULE_04]
      event_set[scs_pkg::EV_DIAG_BIT] = diag_reg && !diag_pending;           // [RULE_03]
      event_set[scs_pkg::EV_IND_BIT]  = !ind_reg && indication_buffered_flag;
      event_set[scs_pkg::EV_DP_BIT]   = dp_next != dp_reg;
      event_clr = '0;
      if (wr_event && wstrb_reg[0]) begin
         event_clr = wdata_reg[scs_pkg::EV_W-1:0];
      end
      // Set beats clear so an event in the clearing cycle survives
      event_next = (event_reg & ~event_clr) | event_set;
      mask_next  = mask_reg;
      if (wr_mask && wstrb_reg[0]) begin
         mask_next = wdata_reg[scs_pkg::EV_W-1:0];
      end
      irq_next = |(event_next & mask_next);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_reg <= scs_pkg::EV_RESET;
         mask_reg  <= scs_pkg::MASK_RESET;
         irq_reg   <= 1'b0;
      end else begin
         event_reg <= event_next;
         mask_reg  <= mask_next;
         irq_reg   <= irq_next;
      end
   end

   // **********
   // AXI4-Lite write path
   // **********
   always_comb begin
      wr_fire      = aw_held_reg && w_held_reg && !bvalid_reg;
      wr_event     = wr_fire && (awaddr_reg == scs_pkg::OFS_EVENT_STATUS);
      wr_mask      = wr_fire && (awaddr_reg == scs_pkg::OFS_EVENT_MASK);
      aw_held_next = aw_held_reg;
      awaddr_next  = awaddr_reg;
      w_held_next  = w_held_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      if (s_axi_awvalid && awready_reg) begin
         aw_held_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_held_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         unique case (awaddr_reg)
            // Status word ignores writes but answers normally
            scs_pkg::OFS_STATUS_WORD:  bresp_next = scs_pkg::RESP_OKAY;      // [RULE_09]
            scs_pkg::OFS_EVENT_STATUS: bresp_next = scs_pkg::RESP_OKAY;
            scs_pkg::OFS_EVENT_MASK:   bresp_next = scs_pkg::RESP_OKAY;
            default:                   bresp_next = scs_pkg::RESP_SLVERR;
         endcase
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      awready_next = !aw_held_next && !bvalid_next;
      wready_next  = !w_held_next && !bvalid_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= '0;
         w_held_reg  <= 1'b0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= scs_pkg::RESP_OKAY;
      end else begin
         aw_held_reg <= aw_held_next;
         awaddr_reg  <= awaddr_next;
         w_held_reg  <= w_held_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
      end
   end

   // **********
   // AXI4-Lite read path
   // **********
   always_comb begin
      rvalid_next = rvalid_reg;
      rresp_next  = rresp_reg;
      rdata_next  = rdata_reg;
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next  = scs_pkg::RESP_OKAY;
         rdata_next  = '0;
         unique case (s_axi_araddr)
            scs_pkg::OFS_STATUS_WORD:
               rdata_next[scs_pkg::SW_W-1:0] = status_word_reg;              // [RULE_09]
            scs_pkg::OFS_EVENT_STATUS:
               rdata_next[scs_pkg::EV_W-1:0] = event_reg;
            scs_pkg::OFS_EVENT_MASK:
               rdata_next[scs_pkg::EV_W-1:0] = mask_reg;
            default:
               rresp_next = scs_pkg::RESP_SLVERR;
         endcase
      end
      arready_next = !rvalid_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= scs_pkg::RESP_OKAY;
         rdata_reg   <= '0;
      end else begin
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
      end
   end

   // **********
   // Outputs
   // **********
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;
   assign irq           = irq_reg;

endmodule : scs_status_word

//--- design/scs_pkg.sv
package scs_pkg;

   // **********
   // Bus geometry
   // **********
   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 32;
   localparam int          STRB_W           = 4;

   // **********
   // Register byte offsets
   // **********
   localparam logic [7:0]  OFS_STATUS_WORD  = 8'h00;
   localparam logic [7:0]  OFS_EVENT_STATUS = 8'h04;
   localparam logic [7:0]  OFS_EVENT_MASK   = 8'h08;

   // **********
   // AXI responses
   // **********
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // **********
   // Status word layout
   // **********
   localparam int          SW_W             = 16;
   localparam int          SW_PASSIVE_BIT   = 0;
   localparam int          SW_IND_BIT       = 1;
   localparam int          SW_DIAG_BIT      = 2;
   localparam int          SW_VIOL_BIT      = 3;
   localparam int          SW_DP_LSB        = 4;
   localparam int          SW_WD_LSB        = 6;
   localparam int          SW_BAUD_LSB      = 8;
   localparam int          SW_REL_LSB       = 12;
   localparam logic [SW_W-1:0] SW_RESET     = 16'h0000;

   // Release number; value is arbitrary
   localparam logic [3:0]  RELEASE_NUMBER   = 4'h1;

   // **********
   // State field codes
   // **********
   localparam logic [1:0]  DP_WAIT_PARAM    = 2'h0;
   localparam logic [1:0]  DP_ILLEGAL       = 2'h3;
   localparam logic [1:0]  WD_BAUD_SEARCH   = 2'h0;
   localparam logic [1:0]  WD_ILLEGAL       = 2'h3;
   localparam logic [3:0]  BAUD_RESET       = 4'h0;

   // **********
   // Event register layout
   // **********
   localparam int          EV_W             = 4;
   localparam int          EV_VIOL_BIT      = 0;
   localparam int          EV_DIAG_BIT      = 1;
   localparam int          EV_IND_BIT       = 2;
   localparam int          EV_DP_BIT        = 3;
   localparam logic [EV_W-1:0] EV_RESET     = 4'h0;
   localparam logic [EV_W-1:0] MASK_RESET   = 4'h0;

   // **********
   // Internal memory folding
   // **********
   localparam int          MEM_ADDR_W       = 11;
   localparam logic [MEM_ADDR_W-1:0] MEM_SIZE_BYTES = 11'h600;
   localparam logic [MEM_ADDR_W-1:0] MEM_FOLD_BYTES = 11'h400;

endpackage : scs_pkg

//--- design/scs_addr_fold.sv
`timescale 1ns/100ps

module scs_addr_fold (
   input  wire logic                               aclk,             // Clock
   input  wire logic                               aresetn,          // Sync reset, low
   input  wire logic                               access_valid,     // Access strobe
   input  wire logic [scs_pkg::MEM_ADDR_W-1:0]     access_addr,      // Requested address
   output logic                                    folded_valid_reg, // Folded strobe
   output logic      [scs_pkg::MEM_ADDR_W-1:0]     folded_addr_reg,  // Folded address
   output logic                                    violation_reg     // Beyond memory pulse
);

   logic                              folded_valid_next;
   logic [scs_pkg::MEM_ADDR_W-1:0]    folded_addr_next;
   logic                              violation_next;
   logic                              beyond;

   // **********
   // Folding
   // **********
   always_comb begin
      beyond            = access_addr >= scs_pkg::MEM_SIZE_BYTES;          // [RULE_04]
      folded_valid_next = access_valid;
      folded_addr_next  = beyond ? access_addr - scs_pkg::MEM_FOLD_BYTES   // [RULE_05]
                                 : access_addr;
      violation_next    = access_valid && beyond;                           // [RULE_04]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         folded_valid_reg <= 1'b0;
         folded_addr_reg  <= '0;
         violation_reg    <= 1'b0;
      end else begin
         folded_valid_reg <= folded_valid_next;
         folded_addr_reg  <= folded_addr_next;
         violation_reg    <= violation_next;
      end
   end

endmodule : scs_addr_fold

//--- verif/scs_status_word_assertions.sv
`timescale 1ns/100ps

module scs_chk (
   input wire logic        aclk,                       // Clock
   input wire logic        aresetn,                    // Reset, low
   input wire logic [7:0]  s_axi_araddr,               // Read address
   input wire logic        s_axi_arvalid,              // AR valid
   input wire logic        s_axi_arready,              // AR ready
   input wire logic [31:0] s_axi_rdata,                // Read data
   input wire logic [1:0]  s_axi_rresp,                // Read response
   input wire logic        s_axi_rvalid,               // R valid
   input wire logic        ctrl_passive_idle,          // Passive idle
   input wire logic        indication_buffered_flag,   // Indication held
   input wire logic        diag_pending,               // Diag pending
   input wire logic [1:0]  slave_protocol_state_field, // Protocol state
   input wire logic [1:0]  watchdog_state_field,       // Watchdog state
   input wire logic [3:0]  baud_code,                  // Baud code
   input wire logic        mem_access_valid,           // Access strobe
   input wire logic [10:0] mem_access_addr,            // Access address
   input wire logic        mem_folded_valid,           // Folded strobe
   input wire logic [10:0] mem_folded_addr             // Folded address
);
   logic [7:0]  ar_q;
   logic [11:0] st_q;
   logic [2:0]  same_cnt;
   wire  [11:0] st = {baud_code, watchdog_state_field, slave_protocol_state_field, 1'b0,
                      diag_pending, indication_buffered_flag, ctrl_passive_idle};

   // Flag, baud and state mirror checks are judged only once inputs sat still; the illegal-code check runs on every OKAY status word read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_q     <= 8'h00;
         st_q     <= 12'h000;
         same_cnt <= 3'h0;
      end else begin
         ar_q     <= (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_q;
         st_q     <= st;
         same_cnt <= (st != st_q) ? 3'h0 : same_cnt + {2'h0, same_cnt != 3'h7};
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_read_done;
      $rose(s_axi_rvalid) && ar_q == scs_pkg::OFS_STATUS_WORD && s_axi_rresp == scs_pkg::RESP_OKAY;
   endsequence
   sequence s_snap;
      s_read_done ##0 (same_cnt >= 3'h3 && st == st_q);
   endsequence
   sequence s_high_access;
      mem_access_valid && mem_access_addr >= scs_pkg::MEM_SIZE_BYTES;
   endsequence

   a_fold_high_addr: assert property (s_high_access |=> mem_folded_valid &&
      mem_folded_addr == $past(mem_access_addr) - scs_pkg::MEM_FOLD_BYTES)
      else $error("folded address wrong above memory");
   a_fold_low_addr: assert property (mem_access_valid &&
      mem_access_addr < scs_pkg::MEM_SIZE_BYTES |=> mem_folded_valid &&
      mem_folded_addr == $past(mem_access_addr)) else $error("low address altered");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_release_nibble: assert property (s_read_done |->
      s_axi_rdata[31:12] == {16'h0000, scs_pkg::RELEASE_NUMBER}) else $error("release wrong");
   a_flags_mirror: assert property (s_snap |-> s_axi_rdata[2:0] == st[2:0])
      else $error("status flags wrong");
   a_baud_mirror: assert property (s_snap |-> s_axi_rdata[11:8] == baud_code)
      else $error("baud code wrong");
   a_state_mirror: assert property (s_snap ##0 st[5:4] != 2'h3 && st[7:6] != 2'h3 |->
      s_axi_rdata[7:4] == st[7:4]) else $error("state fields wrong");
   a_no_illegal_code: assert property (s_read_done |->
      s_axi_rdata[5:4] != 2'h3 && s_axi_rdata[7:6] != 2'h3) else $error("illegal state code");
endmodule : scs_chk

bind scs_status_word scs_chk u_chk (.*);

//--- verif/scs_host_model.sv
`timescale 1ns/100ps

module scs_host_model (
   input  wire logic        aclk,          // Clock
   output logic      [7:0]  s_axi_awaddr,  // AW
   output logic             s_axi_awvalid, // AW
   input  wire logic        s_axi_awready, // AW
   output logic      [31:0] s_axi_wdata,   // W
   output logic      [3:0]  s_axi_wstrb,   // W
   output logic             s_axi_wvalid,  // W
   input  wire logic        s_axi_wready,  // W
   input  wire logic [1:0]  s_axi_bresp,   // B
   input  wire logic        s_axi_bvalid,  // B
   output logic             s_axi_bready,  // B
   output logic      [7:0]  s_axi_araddr,  // AR
   output logic             s_axi_arvalid, // AR
   input  wire logic        s_axi_arready, // AR
   input  wire logic [31:0] s_axi_rdata,   // R
   input  wire logic [1:0]  s_axi_rresp,   // R
   input  wire logic        s_axi_rvalid,  // R
   output logic             s_axi_rready,  // R
   output logic             host_timeout   // A wait ran out
);
   initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
            s_axi_araddr, s_axi_arvalid, s_axi_rready, host_timeout} = '0;

   // AW and W offered together, each dropped on its own ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 64);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      if (!s_axi_bvalid) host_timeout <= 1'b1;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 64);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (!s_axi_rvalid) host_timeout <= 1'b1;
   endtask : rd
endmodule : scs_host_model

//--- verif/slave_controller_status_word_tb_top.sv
`timescale 1ns/100ps

module slave_controller_status_word_tb_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv, ev;
   logic [3:0]  s_axi_wstrb, baud_code;
   logic [1:0]  s_axi_bresp, s_axi_rresp, slave_protocol_state_field, watchdog_state_field, rr, dp, wd;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, host_timeout, irq;
   logic        ctrl_passive_idle, indication_buffered_flag, diag_pending, mem_access_valid;
   logic        mem_folded_valid;
   logic [10:0] mem_access_addr, mem_folded_addr;
   int          err_count = 0;
   int          cmp_count = 0;

   scs_status_word DUT (.*);
   scs_host_model  host (.*);

   always #2.5 aclk = ~aclk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("mismatches=%0d compares=%0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   // State shows two edges on; four are given
   task automatic drive_state(input logic [10:0] v);
      @(posedge aclk);
      {baud_code, watchdog_state_field, slave_protocol_state_field, diag_pending,
       indication_buffered_flag, ctrl_passive_idle} <= v;
      repeat (4) @(posedge aclk);
   endtask : drive_state

   task automatic access(input logic [10:0] a, input logic [10:0] exp);
      @(posedge aclk);
      mem_access_valid <= 1'b1;
      mem_access_addr  <= a;
      @(posedge aclk);
      mem_access_valid <= 1'b0;
      #1;
      chk({31'h0, mem_folded_valid}, 32'h1);
      chk({21'h0, mem_folded_addr}, {21'h0, exp});
   endtask : access

   always @(posedge host_timeout) begin
      err_count++;
      test_done();
   end

   // **********
   // Main sequence
   // **********
   initial begin
      {ctrl_passive_idle, indication_buffered_flag, diag_pending, slave_protocol_state_field,
       watchdog_state_field, baud_code, mem_access_valid, mem_access_addr} = '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      host.rd(8'h00, rv, rr);
      chk(rv, {16'h0, scs_pkg::RELEASE_NUMBER, 12'h000});
      // Last pass: illegal codes, earlier ones stay shown
      for (int i = 0; i < 4; i++) begin
         dp = (i < 3) ? 2'(i) : 2'h3;
         wd = (i < 3) ? 2'(2 - i) : 2'h3;
         drive_state({4'(3 * i + 5), wd, dp, i[0], i[1], ~i[0]});
         ev = {16'h0, scs_pkg::RELEASE_NUMBER, 4'(3 * i + 5), (i < 3) ? {wd, dp} : 4'h2,
               1'b0, i[0], i[1], ~i[0]};
         host.rd(8'h00, rv, rr);
         chk(rv, ev);
      end
      host.wr(8'h00, 32'hFFFF_FFFF, rr);
      chk({30'h0, rr}, {30'h0, scs_pkg::RESP_OKAY});
      host.rd(8'h00, rv, rr);
      chk(rv, ev);
      host.rd(8'h0C, rv, rr);
      chk(rv, 32'h0);
      chk({30'h0, rr}, {30'h0, scs_pkg::RESP_SLVERR});
      host.wr(8'h0C, 32'h0000_0001, rr);
      chk({30'h0, rr}, {30'h0, scs_pkg::RESP_SLVERR});
      host.rd(8'h04, rv, rr);
      chk(rv, 32'h0000_000E);
      host.wr(8'h04, 32'h0000_000F, rr);
      host.rd(8'h04, rv, rr);
      chk(rv, 32'h0);
      access(11'h5FF, 11'h5FF);
      access(11'h600, 11'h200);
      access(11'h7FF, 11'h3FF);
      repeat (3) @(posedge aclk);
      host.rd(8'h00, rv, rr);
      chk({30'h0, rv[3], irq}, 32'h2);
      host.wr(8'h08, 32'h0000_0001, rr);
      repeat (2) @(posedge aclk);
      #1;
      chk({31'h0, irq}, 32'h1);
      host.wr(8'h04, 32'h0000_0001, rr);
      repeat (2) @(posedge aclk);
      #1;
      chk({31'h0, irq}, 32'h0);
      host.rd(8'h00, rv, rr);
      chk({31'h0, rv[3]}, 32'h0);
      test_done();
   end
endmodule : slave_controller_status_word_tb_top
